/* core/dsc_ctrl.sv */
/*
 Drive stop selection and contact-hold controller with an
 AXI4-Lite register slave. Assumes one 20 MHz clock, a
 synchronous active-low reset and a well-behaved bus master.
*/
// Behaviour
// - Setting 0..100 s: coast after that delay
// - Setting 9999 or 8888: ramp to stop
// - Shut off only after full delay elapsed
// - Active flag drops with the shutoff
// - Power-fail or panel stop overrides stop setting
// - Follow frequency command until output shut off
// - Restart after coast from starting frequency
// - Both selects active enter contact-hold, any order
// - Contact enable: 0 normal, 1 permitted, default 0
// - Either select inactive returns to normal
// - Contact-hold outputs low-speed frequency setting
// - Contact-hold frequency limited to 30 Hz
// - Contact stall level alternate, 9999 uses normal
// - Contact carrier at or below 3 Hz, 9999 normal
// - Excitation factor only in contact-hold, 9999 none
// - No contact-hold in panel, jog, remote, auto
// - Contact settings writable only when group is 0
// - Excitation and carrier writable while running
// - Active flag at or above starting frequency
// - Both or neither run command means stop
`timescale 1ns/1ps
module dsc_ctrl
  import dsc_pkg::*;
#(
  parameter int SEC_CYC  = CYC_PER_SEC,
  parameter int STEP_CYC = RAMP_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             output_enable,
  output logic [15:0]      output_freq,
  output logic             motor_active_flag,
  output logic             contact_mode,
  output logic [15:0]      stall_level_eff,
  output logic [15:0]      carrier_eff,
  output logic [15:0]      excitation_eff,
  output logic             excitation_en
);
  typedef struct packed {
    dsc_st_t               st;
    logic [DIV_W-1:0]      div;
    logic [6:0]            sec;
    logic [NCFG-1:0][15:0] cfg;
    logic                  aw_have;
    logic [7:0]            aw_addr;
    logic                  w_have;
    logic [31:0]           w_data;
    logic [3:0]            w_strb;
    logic                  awready;
    logic                  wready;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  arready;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
    logic                  out_en;
    logic                  active;
    logic                  contact;
    logic [15:0]           stall_eff;
    logic [15:0]           car_eff;
    logic [15:0]           exc_eff;
    logic                  exc_en;
  } dsc_state_t;

  dsc_state_t s_r;
  dsc_state_t s_nxt;
  dsc_ramp_if rif ();

  dsc_ramp #(
    .STEP_CYC (STEP_CYC)
  ) u_ramp (
    .aclk    (aclk),
    .aresetn (aresetn),
    .rp      (rif)
  );

  // Word index from a byte address; upper bits out of range fail
  function automatic logic [5:0] reg_ix(input logic [7:0] a);
    reg_ix = a[7:2];
  endfunction : reg_ix

  // Apply byte enables to the low half-word
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0]  be);
    merge = old;
    if (be[0])
      merge[7:0] = d[7:0];
    if (be[1])
      merge[15:8] = d[15:8];
  endfunction : merge

  // Write guard by group select and write-during-run select
  function automatic logic wr_ok(input logic [5:0]  ix,
                                 input logic        running,
                                 input logic [15:0] grp,
                                 input logic [15:0] wsel);
    logic hold_reg;
    logic run_free;
    hold_reg = (ix == 6'(IX_CSEN)) || (ix == 6'(IX_LSF)) ||
               (ix == 6'(IX_ALT)) || (ix == 6'(IX_EXC)) ||
               (ix == 6'(IX_CCAR));
    run_free = (ix == 6'(IX_CTRL)) || (ix == 6'(IX_FCMD)) ||
               (ix == 6'(IX_EXC)) || (ix == 6'(IX_CCAR)) ||
               (ix == 6'(IX_GRP)) || (ix == 6'(IX_WSEL));
    wr_ok = (ix < 6'(NCFG));
    if (hold_reg && grp != V_ZERO)
      wr_ok = 1'b0;
    if (running && wsel == V_ZERO && !run_free)
      wr_ok = 1'b0;
  endfunction : wr_ok

  // Decoded operating conditions
  logic [15:0] ctrl;
  logic [15:0] stop_m;
  logic        run_req;
  logic        stop_ovr;
  logic        ramp_mode;
  logic        dly_mode;
  logic        contact_c;
  logic [15:0] lsf_cap;
  logic [15:0] target_c;

  assign ctrl    = s_r.cfg[IX_CTRL];
  assign stop_m  = s_r.cfg[IX_STOP];
  assign run_req = ctrl[B_FWD] ^ ctrl[B_REV];
  // Stop setting has no say under power-fail or panel stop
  assign stop_ovr  = ctrl[B_PFAIL] | ctrl[B_PSTOP];
  assign dly_mode  = !stop_ovr && (stop_m <= V_MAX_DLY);
  // Reserved values fall back to a ramped stop as the safe choice
  assign ramp_mode = !dly_mode;
  assign contact_c = (s_r.cfg[IX_CSEN][0] == 1'b1) &&
                     ctrl[B_LSS] && ctrl[B_SFS] &&
                     !(ctrl[B_PANEL] | ctrl[B_JOG] |
                       ctrl[B_REMOT] | ctrl[B_AUTO]);
  assign lsf_cap   = (s_r.cfg[IX_LSF] > V_CAP_HZ) ? V_CAP_HZ
                                                  : s_r.cfg[IX_LSF];
  assign target_c  = contact_c ? lsf_cap : s_r.cfg[IX_FCMD];

  // Ramp controls follow the sequencer state
  always_comb begin
    rif.start  = s_r.cfg[IX_SFREQ];
    rif.target = (s_r.st == ST_DECEL) ? V_ZERO : target_c;
    rif.load   = (s_r.st == ST_IDLE) && run_req;
    rif.clear  = (s_r.st == ST_IDLE) && !run_req;
  end

  // Sequencer, bus slave and effective settings
  always_comb begin
    logic [5:0]  wix;
    logic [5:0]  rix;
    logic [15:0] rv;
    logic        tick;
    wix   = reg_ix(s_r.aw_addr);
    rix   = reg_ix(s_axi_araddr);
    rv    = V_ZERO;
    tick  = 1'b0;
    s_nxt = s_r;

    // Stop sequencer
    case (s_r.st)
      ST_IDLE: begin
        if (run_req)
          s_nxt.st = ST_RUN;
      end
      ST_RUN: begin
        if (!run_req && ramp_mode)
          s_nxt.st = ST_DECEL;
        else if (!run_req) begin
          s_nxt.st  = ST_COAST;
          s_nxt.div = '0;
          s_nxt.sec = '0;
        end
      end
      ST_DECEL: begin
        if (run_req)
          s_nxt.st = ST_RUN;
        else if (rif.freq == V_ZERO)
          s_nxt.st = ST_IDLE;
      end
      ST_COAST: begin
        tick = (s_r.div == DIV_W'(SEC_CYC - 1));
        s_nxt.div = tick ? '0 : s_r.div + DIV_W'(1);
        s_nxt.sec = tick ? s_r.sec + 7'h01 : s_r.sec;
        if (run_req)
          s_nxt.st = ST_RUN;
        else if (ramp_mode)
          s_nxt.st = ST_DECEL;
        else if ({9'h000, s_r.sec} >= stop_m)
          s_nxt.st = ST_IDLE;
      end
      default: s_nxt.st = ST_IDLE;
    endcase

    // Write address and data accepted in either order
    if (s_axi_awvalid && s_r.awready) begin
      s_nxt.aw_have = 1'b1;
      s_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_r.wready) begin
      s_nxt.w_have = 1'b1;
      s_nxt.w_data = s_axi_wdata;
      s_nxt.w_strb = s_axi_wstrb;
    end
    if (s_r.bvalid && s_axi_bready)
      s_nxt.bvalid = 1'b0;
    if (s_r.aw_have && s_r.w_have && !s_r.bvalid) begin
      s_nxt.aw_have = 1'b0;
      s_nxt.w_have  = 1'b0;
      s_nxt.bvalid  = 1'b1;
      s_nxt.bresp   = RESP_ERR;
      if (wr_ok(wix, s_r.st != ST_IDLE, s_r.cfg[IX_GRP], s_r.cfg[IX_WSEL])) begin
        s_nxt.cfg[wix[3:0]] = merge(s_r.cfg[wix[3:0]], s_r.w_data, s_r.w_strb);
        s_nxt.bresp         = RESP_OK;
      end
    end
    s_nxt.awready = !s_nxt.aw_have && !s_nxt.bvalid;
    s_nxt.wready  = !s_nxt.w_have && !s_nxt.bvalid;

    // Read channel; status words show live state
    if (s_r.rvalid && s_axi_rready)
      s_nxt.rvalid = 1'b0;
    if (s_axi_arvalid && s_r.arready) begin
      if (rix < 6'(NCFG))
        rv = s_r.cfg[rix[3:0]];
      else if (rix == 6'(IX_STAT))
        rv = {11'h000, s_r.exc_en, s_r.contact, s_r.active, s_r.out_en, run_req};
      else if (rix == 6'(IX_ESTALL))
        rv = s_r.stall_eff;
      else if (rix == 6'(IX_ECAR))
        rv = s_r.car_eff;
      else if (rix == 6'(IX_EEXC))
        rv = s_r.exc_eff;
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata  = (rix == 6'(IX_STAT)) ? {rif.freq, rv} : {16'h0000, rv};
      s_nxt.rresp  = (rix < 6'(NREG)) ? RESP_OK : RESP_ERR;
    end
    s_nxt.arready = !s_nxt.rvalid;

    // Outputs derived from the next state so shutoff and flag align
    s_nxt.out_en  = (s_nxt.st != ST_IDLE);
    s_nxt.active  = s_nxt.out_en && !ctrl[B_DCBRK] &&
                    (rif.freq >= s_r.cfg[IX_SFREQ]);
    s_nxt.contact = contact_c;
    s_nxt.stall_eff = (contact_c && s_r.cfg[IX_ALT] != V_NONE) ?
                      s_r.cfg[IX_ALT] : s_r.cfg[IX_STALL];
    s_nxt.car_eff = (contact_c && rif.freq <= V_LOW_HZ &&
                     s_r.cfg[IX_CCAR] != V_NONE) ?
                    s_r.cfg[IX_CCAR] : s_r.cfg[IX_CAR];
    s_nxt.exc_en  = contact_c && s_r.cfg[IX_EXC] != V_NONE;
    s_nxt.exc_eff = s_nxt.exc_en ? s_r.cfg[IX_EXC] : V_ZERO;
  end

  // State register, reset to constants only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r     <= '0;
      s_r.st  <= ST_IDLE;
      s_r.cfg <= CFG_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign s_axi_awready     = s_r.awready;
  assign s_axi_wready      = s_r.wready;
  assign s_axi_bvalid      = s_r.bvalid;
  assign s_axi_bresp       = s_r.bresp;
  assign s_axi_arready     = s_r.arready;
  assign s_axi_rvalid      = s_r.rvalid;
  assign s_axi_rdata       = s_r.rdata;
  assign s_axi_rresp       = s_r.rresp;
  assign output_enable     = s_r.out_en;
  assign output_freq       = rif.freq;
  assign motor_active_flag = s_r.active;
  assign contact_mode      = s_r.contact;
  assign stall_level_eff   = s_r.stall_eff;
  assign carrier_eff       = s_r.car_eff;
  assign excitation_eff    = s_r.exc_eff;
  assign excitation_en     = s_r.exc_en;

  // Checks on the sequencer and settings
  property p_ramp_stop;
    @(posedge aclk) disable iff (!aresetn)
      (s_r.st == ST_RUN && !run_req && ramp_mode) |=> (s_r.st == ST_DECEL);
  endproperty
  a_ramp_stop: assert property (p_ramp_stop) else $error("ramp stop not taken");

  property p_coast_enter;
    @(posedge aclk) disable iff (!aresetn)
      (s_r.st == ST_RUN && !run_req && dly_mode) |=> (s_r.st == ST_COAST && s_r.sec == 7'h00);
  endproperty
  a_coast_enter: assert property (p_coast_enter) else $error("delay stop not taken");

  property p_no_early_off;
    @(posedge aclk) disable iff (!aresetn)
      (s_r.st == ST_COAST && !run_req && dly_mode && {9'h000, s_r.sec} < stop_m)
      |=> (s_r.st != ST_IDLE);
  endproperty
  a_no_early_off: assert property (p_no_early_off) else $error("shutoff before delay");

  property p_flag_off;
    @(posedge aclk) disable iff (!aresetn)
      (s_r.st == ST_IDLE) |-> (!s_r.active && !s_r.out_en);
  endproperty
  a_flag_off: assert property (p_flag_off) else $error("flag up while off");

  property p_restart;
    @(posedge aclk) disable iff (!aresetn)
      (s_r.st == ST_IDLE && run_req) |=> (rif.freq == $past(s_r.cfg[IX_SFREQ]));
  endproperty
  a_restart: assert property (p_restart) else $error("restart not at start freq");

  property p_contact;
    @(posedge aclk) disable iff (!aresetn)
      contact_c |=> s_r.contact ##1 (!ctrl[B_LSS] || s_r.contact || !$past(contact_c));
  endproperty
  a_contact: assert property (p_contact) else $error("contact mode not entered");

  property p_contact_gate;
    @(posedge aclk) disable iff (!aresetn)
      (s_r.cfg[IX_CSEN][0] == 1'b0 || !ctrl[B_LSS] || !ctrl[B_SFS] || ctrl[B_JOG]) |=> !s_r.contact;
  endproperty
  a_contact_gate: assert property (p_contact_gate) else $error("contact mode when barred");

  property p_cap;
    @(posedge aclk) disable iff (!aresetn)
      contact_c |-> (rif.target <= V_CAP_HZ);
  endproperty
  a_cap: assert property (p_cap) else $error("contact target above cap");

  property p_stall;
    @(posedge aclk) disable iff (!aresetn)
      (!contact_c) |=> (s_r.stall_eff == $past(s_r.cfg[IX_STALL]) && !s_r.exc_en);
  endproperty
  a_stall: assert property (p_stall) else $error("normal settings not in force");

  property p_group;
    @(posedge aclk) disable iff (!aresetn)
      (s_r.aw_have && s_r.w_have && !s_r.bvalid && reg_ix(s_r.aw_addr) == 6'(IX_LSF) &&
       s_r.cfg[IX_GRP] != V_ZERO) |=> (s_r.cfg[IX_LSF] == $past(s_r.cfg[IX_LSF]) && s_r.bresp == RESP_ERR);
  endproperty
  a_group: assert property (p_group) else $error("guarded write accepted");

  property p_active;
    @(posedge aclk) disable iff (!aresetn)
      (s_nxt.out_en && !ctrl[B_DCBRK] && rif.freq >= s_r.cfg[IX_SFREQ]) |=> s_r.active;
  endproperty
  a_active: assert property (p_active) else $error("active flag missing");

  // Main scenarios reached
  c_coast_off: cover property (@(posedge aclk) disable iff (!aresetn)
    s_r.st == ST_COAST ##1 s_r.st == ST_IDLE);
  c_decel_done: cover property (@(posedge aclk) disable iff (!aresetn)
    s_r.st == ST_DECEL ##1 s_r.st == ST_IDLE);
  c_contact: cover property (@(posedge aclk) disable iff (!aresetn)
    s_r.contact && s_r.exc_en);
endmodule : dsc_ctrl

/* core/dsc_pkg.sv */
/*
 Constants, register map and state types for the drive stop
 and contact-hold controller. Assumes a 20 MHz system clock.
*/
package dsc_pkg;
  // Clock and timing
  localparam int CLK_HZ       = 20_000_000;
  localparam int SEC_UNIT_S   = 1;
  localparam int CYC_PER_SEC  = CLK_HZ * SEC_UNIT_S;
  localparam int RAMP_STEP_US = 1000;
  localparam int RAMP_CYC     = CLK_HZ / 1_000_000 * RAMP_STEP_US;
  localparam int DIV_W        = 25;

  // Register indices; byte address is four times the index
  localparam int NCFG      = 13;
  localparam int NREG      = 17;
  localparam int IX_CTRL   = 0;
  localparam int IX_STOP   = 1;
  localparam int IX_CSEN   = 2;
  localparam int IX_LSF    = 3;
  localparam int IX_FCMD   = 4;
  localparam int IX_STALL  = 5;
  localparam int IX_ALT    = 6;
  localparam int IX_EXC    = 7;
  localparam int IX_CCAR   = 8;
  localparam int IX_CAR    = 9;
  localparam int IX_SFREQ  = 10;
  localparam int IX_GRP    = 11;
  localparam int IX_WSEL   = 12;
  localparam int IX_STAT   = 13;
  localparam int IX_ESTALL = 14;
  localparam int IX_ECAR   = 15;
  localparam int IX_EEXC   = 16;

  // Control register bits
  localparam int B_FWD   = 0;
  localparam int B_REV   = 1;
  localparam int B_LSS   = 2;
  localparam int B_SFS   = 3;
  localparam int B_PFAIL = 4;
  localparam int B_PSTOP = 5;
  localparam int B_PANEL = 6;
  localparam int B_JOG   = 7;
  localparam int B_REMOT = 8;
  localparam int B_AUTO  = 9;
  localparam int B_DCBRK = 10;

  // Setting values
  localparam logic [15:0] V_NONE     = 16'h270F; // 9999
  localparam logic [15:0] V_RAMP_ALT = 16'h22B8; // 8888
  localparam logic [15:0] V_MAX_DLY  = 16'h0064; // 100 s
  localparam logic [15:0] V_CAP_HZ   = 16'h001E; // 30 Hz
  localparam logic [15:0] V_LOW_HZ   = 16'h0003; // 3 Hz
  localparam logic [15:0] V_ZERO     = 16'h0000;
  localparam logic [15:0] V_LSF_DEF  = 16'h000A; // 10 Hz

  // Reset values, index 0 at the right
  localparam logic [NCFG-1:0][15:0] CFG_RST = {
    16'h0000, 16'h0000, 16'h0000, 16'h0000, V_NONE, V_NONE,
    V_NONE, 16'h0000, 16'h0000, V_LSF_DEF, 16'h0000, V_NONE,
    16'h0000};

  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_RUN   = 4'h2,
    ST_DECEL = 4'h4,
    ST_COAST = 4'h8
  } dsc_st_t;
endpackage : dsc_pkg

/* core/dsc_ramp_if.sv */
/*
 Carrier between the controller and its frequency ramp.
 Assumes both ends share one clock.
*/
`timescale 1ns/1ps
interface dsc_ramp_if;
  logic [15:0] target;
  logic [15:0] start;
  logic        load;
  logic        clear;
  logic [15:0] freq;
  modport ctl (output target, output start, output load, output clear, input freq);
  modport rmp (input target, input start, input load, input clear, output freq);
endinterface : dsc_ramp_if

/* core/dsc_ramp.sv */
/*
 Frequency ramp: steps output frequency one Hz per step period
 toward the target. Assumes controls from the same clock domain.
*/
`timescale 1ns/1ps
module dsc_ramp
  import dsc_pkg::*;
#(
  parameter int STEP_CYC = RAMP_CYC
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  dsc_ramp_if.rmp   rp
);
  typedef struct packed {
    logic [DIV_W-1:0] div;
    logic [15:0]      freq;
  } dsc_ramp_st_t;

  dsc_ramp_st_t s_r;
  dsc_ramp_st_t s_nxt;

  // Clear beats load; restart jumps to the start value
  always_comb begin
    s_nxt = s_r;
    if (rp.clear) begin
      s_nxt.freq = V_ZERO;
      s_nxt.div  = '0;
    end else if (rp.load) begin
      s_nxt.freq = rp.start;
      s_nxt.div  = '0;
    end else if (s_r.div == DIV_W'(STEP_CYC - 1)) begin
      s_nxt.div = '0;
      if (s_r.freq < rp.target)
        s_nxt.freq = s_r.freq + 16'h0001;
      else if (s_r.freq > rp.target)
        s_nxt.freq = s_r.freq - 16'h0001;
    end else begin
      s_nxt.div = s_r.div + DIV_W'(1);
    end
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign rp.freq = s_r.freq;
endmodule : dsc_ramp

/* tb/dsc_host.sv */
/*
 AXI4-Lite master model of the network host.
 Assumes the slave's clock; the bench calls its tasks.
*/
`timescale 1ns/1ps
module dsc_host (
  input  wire logic        aclk,
  output logic [7:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic             wvalid,
  input  wire logic        wready,
  output logic             bready,
  input  wire logic        bvalid,
  output logic [7:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  output logic             rready,
  input  wire logic        rvalid
);
  // Idle bus; all valid and ready lines start low
  initial begin
    {awaddr, awvalid, wdata, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end

  // Both channels offered at once, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    fork
      begin
        do @(posedge aclk); while (!awready);
        awvalid <= 1'b0;
      end
      begin
        do @(posedge aclk); while (!wready);
        wvalid <= 1'b0;
      end
    join
    while (!bvalid) @(posedge aclk);
    bready <= 1'b0;
  endtask : wr

  // Read address released when taken; ready held until the answer is sampled
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge aclk);
    rready <= 1'b0;
  endtask : rd
endmodule : dsc_host

/* tb/dsc_ctrl_tb_top.sv */
/*
 Bench for the stop and contact-hold controller.
 Assumes the host model drives the register bus.
*/
`timescale 1ns/1ps
module dsc_ctrl_tb_top;
  import dsc_pkg::*;
  localparam int SC = 200;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bready, bvalid;
  logic        arvalid, arready, rready, rvalid, oe, act, cm, xen, fl;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic [15:0] fo, stl, car, exc, f;
  logic [33:0] exp_q[$];
  int          n_fail = 0, n_tests = 0, cyc = 0, k;

  // 20 MHz clock
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // Short second and ramp step keep the run brief
  dsc_ctrl #(.SEC_CYC(SC), .STEP_CYC(2)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .output_enable(oe), .output_freq(fo), .motor_active_flag(act), .contact_mode(cm),
    .stall_level_eff(stl), .carrier_eff(car), .excitation_eff(exc), .excitation_en(xen));

  dsc_host host_u (
    .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wvalid(wvalid), .wready(wready), .bready(bready), .bvalid(bvalid), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rready(rready), .rvalid(rvalid));

  task automatic give_verdict();
    if (n_fail == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [33:0] got, input logic [33:0] want);
    n_tests++;
    if (got !== want) begin
      n_fail++;
      $display("Error at %0t: saw %h, want %h", $time, got, want);
    end
  endtask : chk

  // Bus answers paired with the oldest note
  always @(posedge aclk) begin
    if (bvalid && bready) chk({bresp, 32'h0}, exp_q.pop_front());
    if (rvalid && rready) chk({rresp, rdata}, exp_q.pop_front());
  end

  // Hang guard, well above the expected length
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      give_verdict();
    end
  end

  task automatic wreg(input int ix, input logic [31:0] d, input logic [1:0] rs);
    exp_q.push_back({rs, 32'h0});
    host_u.wr(8'(ix * 4), d);
  endtask : wreg

  task automatic rreg(input int ix, input logic [31:0] d, input logic [1:0] rs);
    exp_q.push_back({rs, d});
    host_u.rd(8'(ix * 4));
  endtask : rreg

  task automatic wait_f(input logic [15:0] w);
    int n;
    n = 0;
    while (fo !== w && n < 500) begin
      @(posedge aclk);
      n++;
    end
    chk({18'h0, fo}, {18'h0, w});
  endtask : wait_f

  // Counts cycles to shutoff; fl keeps the flag seen just before
  task automatic wait_off();
    k = 0;
    while (oe !== 1'b0 && k < 2000) begin
      fl = act;
      @(posedge aclk);
      k++;
    end
  endtask : wait_off

  initial begin
    aresetn = 1'b0;
    void'($urandom(69));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < NCFG; i++) rreg(i, {16'h0, CFG_RST[i]}, RESP_OK);
    rreg(NREG, 32'h0, RESP_ERR);
    wreg(NREG, 32'h1, RESP_ERR);
    f = 16'(14 + $urandom % 12);
    wreg(IX_SFREQ, 32'h5, RESP_OK);
    wreg(IX_FCMD, {16'h0, f}, RESP_OK);
    wreg(IX_CTRL, 32'h3, RESP_OK);
    rreg(IX_STAT, 32'h0, RESP_OK);
    // Both ramped stop codes, both directions
    for (int i = 0; i < 2; i++) begin
      wreg(IX_STOP, {16'h0, i ? V_RAMP_ALT : V_NONE}, RESP_OK);
      wreg(IX_FCMD, {16'h0, f}, RESP_OK);
      wreg(IX_CTRL, 32'h1 << i, RESP_OK);
      wait_f(f);
      chk(act, 1'b1);
      wreg(IX_FCMD, {16'h0, f - 16'h4}, RESP_OK);
      wait_f(f - 16'h4);
      wreg(IX_CTRL, i ? 32'h3 : 32'h0, RESP_OK);
      chk(oe, 1'b1);
      wait_off();
      chk({fo, act}, 17'h0);
    end
    // Delayed shutoff, restart mid-coast, then overriding stops
    wreg(IX_STOP, 32'h2, RESP_OK);
    wreg(IX_CTRL, 32'h1, RESP_OK);
    wait_f(f - 16'h4);
    wreg(IX_CTRL, 32'h0, RESP_OK);
    wait_off();
    chk(k >= 2 * SC - 4 && k <= 2 * SC + 4, 1'b1);
    chk({fl, act}, 2'b10);
    for (int i = 0; i < 2; i++) begin
      wreg(IX_CTRL, 32'h1, RESP_OK);
      wait_f(f - 16'h4);
      wreg(IX_CTRL, 32'h0, RESP_OK);
      repeat (SC) @(posedge aclk);
      wreg(IX_CTRL, 32'h1, RESP_OK);
      chk({oe, fo}, {1'b1, f - 16'h4});
      wreg(IX_CTRL, 32'h0, RESP_OK);
      wait_off();
      // Restart once the output is off: begins at starting frequency
      wreg(IX_CTRL, 32'h1, RESP_OK);
      @(posedge aclk);
      chk({oe, fo}, {1'b1, 16'h5});
      wait_f(f - 16'h4);
      wreg(IX_CTRL, 32'h1 << (i ? B_PSTOP : B_PFAIL), RESP_OK);
      wait_off();
      chk(k < SC, 1'b1);
    end
    // Selects ignored while contact-hold disabled
    wreg(IX_LSF, 32'h28, RESP_OK);
    wreg(IX_STALL, 32'h78, RESP_OK);
    wreg(IX_CAR, 32'h7, RESP_OK);
    wreg(IX_CTRL, 32'hD, RESP_OK);
    wait_f(f - 16'h4);
    chk({cm, xen, stl}, {2'b00, 16'h78});
    wreg(IX_EXC, 32'h96, RESP_OK);
    wreg(IX_CCAR, 32'h4, RESP_OK);
    wreg(IX_CSEN, 32'h1, RESP_ERR);
    wreg(IX_CTRL, 32'h0, RESP_OK);
    wait_off();
    wreg(IX_CSEN, 32'h1, RESP_OK);
    // Entry in either order, limit, alternates, exit
    for (int i = 0; i < 2; i++) begin
      if (i) wreg(IX_LSF, 32'h2, RESP_OK);
      if (i) wreg(IX_ALT, 32'h32, RESP_OK);
      wreg(IX_CTRL, i ? 32'h9 : 32'h5, RESP_OK);
      wait_f(f - 16'h4);
      chk(cm, 1'b0);
      wreg(IX_CTRL, 32'hD, RESP_OK);
      wait_f(i ? 16'h2 : V_CAP_HZ);
      chk({cm, xen, exc}, {2'b11, 16'h96});
      chk({stl, car}, i ? {16'h32, 16'h4} : {16'h78, 16'h7});
      wreg(IX_CTRL, i ? 32'h5 : 32'h9, RESP_OK);
      wait_f(f - 16'h4);
      chk({cm, xen, exc, stl}, {2'b00, 16'h0, 16'h78});
      wreg(IX_CTRL, 32'h0, RESP_OK);
      wait_off();
    end
    // Excluding operations block contact-hold
    foreach (exp_q[j]) chk(1'b0, 1'b1);
    for (int b = B_PANEL; b <= B_AUTO; b++) begin
      wreg(IX_CTRL, 32'hD | (32'h1 << b), RESP_OK);
      rreg(IX_CSEN, 32'h1, RESP_OK);
      chk(cm, 1'b0);
    end
    // DC braking keeps the running flag down with output on
    wreg(IX_CTRL, 32'h1 | (32'h1 << B_DCBRK), RESP_OK);
    rreg(IX_CSEN, 32'h1, RESP_OK);
    chk({oe, act}, 2'b10);
    wreg(IX_CTRL, 32'h0, RESP_OK);
    wait_off();
    // Group selection guards the contact settings
    wreg(IX_GRP, 32'h1, RESP_OK);
    wreg(IX_LSF, 32'h9, RESP_ERR);
    rreg(IX_LSF, 32'h2, RESP_OK);
    wreg(IX_GRP, 32'h0, RESP_OK);
    wreg(IX_LSF, 32'h9, RESP_OK);
    give_verdict();
  end
endmodule : dsc_ctrl_tb_top
